/* File: rtl/arsf_top.sv */
`timescale 1ns/10ps
`default_nettype none
module arsf_top #(
  parameter logic [27:0] MAX_LBA = 28'h00FFFFF,
  parameter logic [7:0] CURRENT_MIN = 8'h01,
  parameter logic [7:0] CURRENT_MAX = 8'h64,
  parameter logic [7:0] ECC_VENDOR_BYTES = 8'h04
) (
  input wire logic sys_clk_in, // Clock
  input wire logic rst_n_in, // Async reset, low
  input wire logic [5:0] s_axi_awaddr_in, // Write address
  input wire logic s_axi_awvalid_in, // Write address valid
  output logic s_axi_awready_out, // Write address ready
  input wire logic [31:0] s_axi_wdata_in, // Write data
  input wire logic [3:0] s_axi_wstrb_in, // Write strobes
  input wire logic s_axi_wvalid_in, // Write data valid
  output logic s_axi_wready_out, // Write data ready
  output logic [1:0] s_axi_bresp_out, // Write response
  output logic s_axi_bvalid_out, // Write response valid
  input wire logic s_axi_bready_in, // Write response ready
  input wire logic [5:0] s_axi_araddr_in, // Read address
  input wire logic s_axi_arvalid_in, // Read address valid
  output logic s_axi_arready_out, // Read address ready
  output logic [31:0] s_axi_rdata_out, // Read data
  output logic [1:0] s_axi_rresp_out, // Read response
  output logic s_axi_rvalid_out, // Read data valid
  input wire logic s_axi_rready_in, // Read data ready
  output logic media_req_out, // Sector fetch pulse
  output logic [27:0] media_lba_out, // Sector to fetch
  input wire logic media_wvalid_in, // Sector word valid
  input wire logic [31:0] media_wdata_in, // Sector word
  input wire logic media_done_in, // Sector fetch done
  input wire logic media_err_in, // Fetch failed, with done
  output logic flush_req_out, // Cache flush pulse
  input wire logic flush_done_in, // Cache flush done
  output logic intrq_out, // Host interrupt level
  output logic eight_bit_out, // 8-bit transfers on
  output logic wcache_out, // Write cache on
  output logic [7:0] xfer_mode_out, // Transfer type and mode
  output logic apm_on_out, // Power management on
  output logic [7:0] apm_level_out, // Power management level
  output logic pl1_on_out, // Power level 1 on
  output logic ext_pwr_out, // Extended power on
  output logic lookahead_out, // Read look-ahead on
  output logic por_restore_out, // Restore defaults at soft reset
  output logic [7:0] ecc_bytes_out, // Long command ECC bytes
  output logic [7:0] current_limit_out // Host current setting
);
  import arsf_pkg::*;

  // ==========================================
  // Task file and status
  arsf_state_t state;
  logic [7:0] feature, count, a_low, a_mid, a_high, drive, err_reg;
  logic busy, data_request_bit, err, verifying;
  logic [8:0] remain;
  logic [6:0] widx, ridx;
  logic [31:0] buffer [SECTOR_WORDS];
  wire [27:0] lba = {drive[3:0], a_high, a_mid, a_low};
  wire [27:0] lba_next = lba + 28'h0000001;
  wire [7:0] status = {busy, ~busy, 2'b00, data_request_bit, 2'b00, err};

  // ==========================================
  // Bus slave
  logic aw_hold, w_hold;
  logic [3:0] aw_idx;
  logic [7:0] w_byte;
  logic w_lane;
  assign s_axi_awready_out = !aw_hold && !s_axi_bvalid_out;
  assign s_axi_wready_out = !w_hold && !s_axi_bvalid_out;
  assign s_axi_arready_out = !s_axi_rvalid_out;
  wire aw_fire = s_axi_awvalid_in && s_axi_awready_out;
  wire w_fire = s_axi_wvalid_in && s_axi_wready_out;
  wire ar_fire = s_axi_arvalid_in && s_axi_arready_out;
  wire do_write = aw_hold && w_hold && !s_axi_bvalid_out;
  wire wr_mapped = (aw_idx >= IDX_FEATURE) && (aw_idx <= IDX_COMMAND);
  wire wr_ok = do_write && wr_mapped && w_lane && !busy;
  wire [3:0] ar_idx = s_axi_araddr_in[5:2];
  wire rd_mapped = ar_idx <= IDX_COMMAND;
  wire rd_data = ar_fire && (ar_idx == IDX_DATA) && data_request_bit;
  wire rd_status = ar_fire && (ar_idx == IDX_COMMAND);
  wire cmd_wr = wr_ok && (aw_idx == IDX_COMMAND);
  logic [31:0] rd_value;
  always_comb begin
    case (ar_idx)
      IDX_DATA: rd_value = data_request_bit ? buffer[ridx] : 32'h0000_0000;
      IDX_FEATURE: rd_value = {24'h000000, err_reg};
      IDX_COUNT: rd_value = {24'h000000, count};
      IDX_ADDR_LOW: rd_value = {24'h000000, a_low};
      IDX_ADDR_MID: rd_value = {24'h000000, a_mid};
      IDX_ADDR_HIGH: rd_value = {24'h000000, a_high};
      IDX_DRIVE: rd_value = {24'h000000, drive};
      IDX_COMMAND: rd_value = {24'h000000, status};
      default: rd_value = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_idx <= 4'h0;
      w_byte <= 8'h00;
      w_lane <= 1'b0;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= RESP_OKAY;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rresp_out <= RESP_OKAY;
      s_axi_rdata_out <= 32'h0000_0000;
    end else begin
      if (aw_fire) begin
        aw_hold <= 1'b1;
        aw_idx <= s_axi_awaddr_in[5:2];
      end
      if (w_fire) begin
        w_hold <= 1'b1;
        w_byte <= s_axi_wdata_in[7:0];
        w_lane <= s_axi_wstrb_in[0];
      end
      if (do_write) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out <= wr_mapped ? RESP_OKAY : RESP_DECERR;
      end else if (s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
      end
      if (ar_fire) begin
        s_axi_rvalid_out <= 1'b1;
        s_axi_rresp_out <= rd_mapped ? RESP_OKAY : RESP_DECERR;
        s_axi_rdata_out <= rd_value;
      end else if (s_axi_rready_in) begin
        s_axi_rvalid_out <= 1'b0;
      end
    end
  end

  // ==========================================
  // Feature decode
  wire [4:0] xt = count[7:3];
  wire xt_ok = (xt == XT_PIO_DEFAULT && count[2:1] == 2'b00) || xt == XT_PIO_FLOW
    || xt == XT_MW_DMA || xt == XT_ULTRA_DMA;
  wire apm_ok = count != 8'h00 && count != 8'hFF;
  logic ft_ok;
  always_comb begin
    case (feature)
      FT_8BIT_ON, FT_8BIT_OFF, FT_WCACHE_ON, FT_WCACHE_OFF, FT_APM_OFF: ft_ok = 1'b1;
      FT_EXTPWR_ON, FT_EXTPWR_OFF, FT_PL1_ON, FT_PL1_OFF: ft_ok = 1'b1;
      FT_ECC_VENDOR, FT_ECC_FOUR, FT_LOOKAHEAD_OFF, FT_LOOKAHEAD_ON: ft_ok = 1'b1;
      FT_POR_OFF, FT_POR_ON, FT_CURRENT: ft_ok = 1'b1;
      FT_NOP_A, FT_NOP_B, FT_NOP_C: ft_ok = 1'b1;
      FT_XFER_MODE: ft_ok = xt_ok;
      FT_APM_ON: ft_ok = apm_ok;
      default: ft_ok = 1'b0;
    endcase
  end
  wire is_read = w_byte == OP_READ0 || w_byte == OP_READ1;
  wire is_verify = w_byte == OP_VERIFY0 || w_byte == OP_VERIFY1;
  wire is_recal = w_byte[7:4] == OP_RECAL_HI;
  wire is_seek = w_byte[7:4] == OP_SEEK_HI;
  wire is_setf = w_byte == OP_SET_FEATURES;
  wire setf_go = cmd_wr && is_setf && ft_ok;

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      eight_bit_out <= 1'b0;
      wcache_out <= 1'b0;
      xfer_mode_out <= RST_XFER_MODE;
      apm_on_out <= 1'b0;
      apm_level_out <= RST_APM_LEVEL;
      pl1_on_out <= 1'b1;
      ext_pwr_out <= 1'b0;
      lookahead_out <= 1'b0;
      por_restore_out <= 1'b1;
      ecc_bytes_out <= ECC_FOUR_BYTES;
      current_limit_out <= RST_CURRENT;
    end else if (setf_go) begin
      case (feature)
        FT_8BIT_ON: eight_bit_out <= 1'b1;
        FT_8BIT_OFF: eight_bit_out <= 1'b0;
        FT_WCACHE_ON: wcache_out <= 1'b1;
        FT_XFER_MODE: xfer_mode_out <= count;
        FT_APM_ON: begin
          apm_on_out <= 1'b1;
          apm_level_out <= count;
        end
        FT_APM_OFF: apm_on_out <= 1'b0;
        FT_PL1_ON: pl1_on_out <= 1'b1;
        FT_PL1_OFF: pl1_on_out <= 1'b0;
        FT_EXTPWR_ON: ext_pwr_out <= 1'b1;
        FT_EXTPWR_OFF: ext_pwr_out <= 1'b0;
        FT_LOOKAHEAD_OFF: lookahead_out <= 1'b0;
        FT_LOOKAHEAD_ON: lookahead_out <= 1'b1;
        FT_POR_OFF: por_restore_out <= 1'b0;
        FT_POR_ON: por_restore_out <= 1'b1;
        FT_ECC_VENDOR: ecc_bytes_out <= ECC_VENDOR_BYTES;
        FT_ECC_FOUR: ecc_bytes_out <= ECC_FOUR_BYTES;
        FT_CURRENT: current_limit_out <= count;
        default: ;
      endcase
    end else if (state == ARSF_FLUSH && flush_done_in) begin
      wcache_out <= 1'b0;
    end
  end

  // ==========================================
  // Command sequencer
  assign media_lba_out = lba;
  always_ff @(posedge sys_clk_in) begin
    if (state == ARSF_WAIT && media_wvalid_in) begin
      buffer[widx] <= media_wdata_in;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= ARSF_IDLE;
      feature <= 8'h00;
      count <= RST_COUNT;
      a_low <= RST_ADDR_LOW;
      a_mid <= 8'h00;
      a_high <= 8'h00;
      drive <= RST_DRIVE;
      err_reg <= 8'h00;
      busy <= 1'b0;
      data_request_bit <= 1'b0;
      err <= 1'b0;
      verifying <= 1'b0;
      remain <= 9'h000;
      widx <= 7'h00;
      ridx <= 7'h00;
      intrq_out <= 1'b0;
      media_req_out <= 1'b0;
      flush_req_out <= 1'b0;
    end else begin
      media_req_out <= 1'b0;
      flush_req_out <= 1'b0;
      if (rd_status) intrq_out <= 1'b0;
      if (wr_ok) begin
        case (aw_idx)
          IDX_FEATURE: feature <= w_byte;
          IDX_COUNT: count <= w_byte;
          IDX_ADDR_LOW: a_low <= w_byte;
          IDX_ADDR_MID: a_mid <= w_byte;
          IDX_ADDR_HIGH: a_high <= w_byte;
          IDX_DRIVE: drive <= {1'b1, w_byte[6], 1'b1, w_byte[4:0]};
          default: ;
        endcase
      end
      case (state)
        ARSF_IDLE: begin
          if (cmd_wr) begin
            err <= 1'b0;
            err_reg <= 8'h00;
            if (is_read || is_verify) begin
              busy <= 1'b1;
              verifying <= is_verify;
              remain <= (count == 8'h00) ? 9'h100 : {1'b0, count};
              state <= ARSF_FETCH;
            end else if (is_seek && lba > MAX_LBA) begin
              err <= 1'b1;
              err_reg[ER_IDNF] <= 1'b1;
              intrq_out <= 1'b1;
            end else if (is_recal || is_seek) begin
              intrq_out <= 1'b1;
            end else if (setf_go && feature == FT_WCACHE_OFF) begin
              busy <= 1'b1;
              flush_req_out <= 1'b1;
              state <= ARSF_FLUSH;
            end else if (setf_go) begin
              intrq_out <= 1'b1;
              if (feature == FT_CURRENT) begin
                a_mid <= CURRENT_MIN;
                a_high <= CURRENT_MAX;
              end
            end else begin
              err <= 1'b1;
              err_reg[ER_ABRT] <= 1'b1;
              intrq_out <= 1'b1;
            end
          end
        end
        ARSF_FETCH: begin
          busy <= 1'b1;
          widx <= 7'h00;
          media_req_out <= 1'b1;
          state <= ARSF_WAIT;
        end
        ARSF_WAIT: begin
          if (media_wvalid_in) widx <= widx + 7'h01;
          if (media_done_in && media_err_in) begin
            busy <= 1'b0;
            err <= 1'b1;
            err_reg[ER_UNC] <= 1'b1;
            intrq_out <= 1'b1;
            if (verifying) count <= remain[7:0];
            state <= ARSF_IDLE;
          end else if (media_done_in && verifying) begin
            if (remain == 9'h001) begin
              busy <= 1'b0;
              intrq_out <= 1'b1;
              state <= ARSF_IDLE;
            end else begin
              remain <= remain - 9'h001;
              {drive[3:0], a_high, a_mid, a_low} <= lba_next;
              state <= ARSF_FETCH;
            end
          end else if (media_done_in) begin
            busy <= 1'b0;
            data_request_bit <= 1'b1;
            ridx <= 7'h00;
            intrq_out <= 1'b1;
            state <= ARSF_XFER;
          end
        end
        ARSF_XFER: begin
          if (rd_data) begin
            ridx <= ridx + 7'h01;
            if (ridx == 7'(SECTOR_WORDS - 1)) begin
              data_request_bit <= 1'b0;
              if (remain == 9'h001) begin
                state <= ARSF_IDLE;
              end else begin
                remain <= remain - 9'h001;
                {drive[3:0], a_high, a_mid, a_low} <= lba_next;
                busy <= 1'b1;
                state <= ARSF_FETCH;
              end
            end
          end
        end
        ARSF_FLUSH: begin
          if (flush_done_in) begin
            busy <= 1'b0;
            intrq_out <= 1'b1;
            state <= ARSF_IDLE;
          end
        end
        default: state <= ARSF_IDLE;
      endcase
    end
  end
endmodule : arsf_top
`default_nettype wire

/* File: rtl/arsf_pkg.sv */
package arsf_pkg;
  // Register indices, byte address is four times the index
  localparam logic [3:0] IDX_DATA = 4'h0;
  localparam logic [3:0] IDX_FEATURE = 4'h1;
  localparam logic [3:0] IDX_COUNT = 4'h2;
  localparam logic [3:0] IDX_ADDR_LOW = 4'h3;
  localparam logic [3:0] IDX_ADDR_MID = 4'h4;
  localparam logic [3:0] IDX_ADDR_HIGH = 4'h5;
  localparam logic [3:0] IDX_DRIVE = 4'h6;
  localparam logic [3:0] IDX_COMMAND = 4'h7;
  // Opcodes
  localparam logic [7:0] OP_READ0 = 8'h20;
  localparam logic [7:0] OP_READ1 = 8'h21;
  localparam logic [7:0] OP_VERIFY0 = 8'h40;
  localparam logic [7:0] OP_VERIFY1 = 8'h41;
  localparam logic [3:0] OP_RECAL_HI = 4'h1;
  localparam logic [3:0] OP_SEEK_HI = 4'h7;
  localparam logic [7:0] OP_SET_FEATURES = 8'hEF;
  // Feature codes
  localparam logic [7:0] FT_8BIT_ON = 8'h01;
  localparam logic [7:0] FT_WCACHE_ON = 8'h02;
  localparam logic [7:0] FT_XFER_MODE = 8'h03;
  localparam logic [7:0] FT_APM_ON = 8'h05;
  localparam logic [7:0] FT_EXTPWR_ON = 8'h09;
  localparam logic [7:0] FT_PL1_ON = 8'h0A;
  localparam logic [7:0] FT_ECC_VENDOR = 8'h44;
  localparam logic [7:0] FT_LOOKAHEAD_OFF = 8'h55;
  localparam logic [7:0] FT_POR_OFF = 8'h66;
  localparam logic [7:0] FT_NOP_A = 8'h69;
  localparam logic [7:0] FT_8BIT_OFF = 8'h81;
  localparam logic [7:0] FT_WCACHE_OFF = 8'h82;
  localparam logic [7:0] FT_APM_OFF = 8'h85;
  localparam logic [7:0] FT_EXTPWR_OFF = 8'h89;
  localparam logic [7:0] FT_PL1_OFF = 8'h8A;
  localparam logic [7:0] FT_NOP_B = 8'h96;
  localparam logic [7:0] FT_NOP_C = 8'h97;
  localparam logic [7:0] FT_CURRENT = 8'h9A;
  localparam logic [7:0] FT_LOOKAHEAD_ON = 8'hAA;
  localparam logic [7:0] FT_ECC_FOUR = 8'hBB;
  localparam logic [7:0] FT_POR_ON = 8'hCC;
  // Transfer type field values
  localparam logic [4:0] XT_PIO_DEFAULT = 5'h00;
  localparam logic [4:0] XT_PIO_FLOW = 5'h01;
  localparam logic [4:0] XT_MW_DMA = 5'h04;
  localparam logic [4:0] XT_ULTRA_DMA = 5'h08;
  // Status and error bit positions
  localparam int ST_BUSY = 7;
  localparam int ST_READY = 6;
  localparam int ST_DRQ = 3;
  localparam int ST_ERR = 0;
  localparam int ER_UNC = 6;
  localparam int ER_IDNF = 4;
  localparam int ER_ABRT = 2;
  // Words per 512-byte sector
  localparam int SECTOR_WORDS = 128;
  // Reset values
  localparam logic [7:0] RST_APM_LEVEL = 8'hFE;
  localparam logic [7:0] RST_XFER_MODE = 8'h00;
  localparam logic [7:0] RST_COUNT = 8'h01;
  localparam logic [7:0] RST_ADDR_LOW = 8'h01;
  localparam logic [7:0] RST_DRIVE = 8'hA0;
  localparam logic [7:0] RST_CURRENT = 8'hFF;
  localparam logic [7:0] ECC_FOUR_BYTES = 8'h04;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;
  typedef enum logic [2:0] {ARSF_IDLE, ARSF_FETCH, ARSF_WAIT, ARSF_XFER, ARSF_FLUSH} arsf_state_t;
endpackage : arsf_pkg

/* File: tb/arsf_top_sva.sv */
`timescale 1ns/10ps
`default_nettype none
module arsf_checker
  import arsf_pkg::*;
(
  input wire logic sys_clk_in, // Clock
  input wire logic rst_n_in, // Reset, low
  input wire logic s_axi_awvalid_in, // Write address valid
  input wire logic s_axi_awready_out, // Write address ready
  input wire logic s_axi_wvalid_in, // Write data valid
  input wire logic s_axi_wready_out, // Write data ready
  input wire logic s_axi_bvalid_out, // Write response valid
  input wire logic [5:0] s_axi_araddr_in, // Read address
  input wire logic s_axi_arvalid_in, // Read address valid
  input wire logic s_axi_arready_out, // Read address ready
  input wire logic [31:0] s_axi_rdata_out, // Read data
  input wire logic [1:0] s_axi_rresp_out, // Read response
  input wire logic s_axi_rvalid_out, // Read data valid
  input wire logic media_req_out, // Fetch pulse
  input wire logic [27:0] media_lba_out, // Fetch address
  input wire logic flush_req_out, // Flush pulse
  input wire logic intrq_out, // Interrupt
  input wire logic por_restore_out, // Restore defaults
  input wire logic [7:0] ecc_bytes_out, // ECC bytes
  input wire logic [7:0] current_limit_out // Current setting
);
  logic rd_take;
  logic stat_rd;
  assign rd_take = s_axi_arvalid_in && s_axi_arready_out;
  assign stat_rd = rd_take && (s_axi_araddr_in[5:2] == 4'h7);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  a_wr_answer:
    assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
      |-> ##[1:2] s_axi_bvalid_out) else $error("write response missing");
  a_wr_blocked:
    assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out) else $error("write taken early");
  a_rd_answer:
    assert property (rd_take |=> s_axi_rvalid_out && !s_axi_arready_out) else $error("read answer wrong");
  a_rd_unmapped:
    assert property (rd_take && s_axi_araddr_in[5:2] > 4'h7 |=> s_axi_rresp_out == RESP_DECERR
      && s_axi_rdata_out == 32'h0) else $error("unmapped read not refused");
  a_req_pulse:
    assert property (media_req_out |=> !media_req_out && $stable(media_lba_out)) else $error("fetch pulse wrong");
  a_flush_pulse:
    assert property (flush_req_out |=> !flush_req_out) else $error("flush pulse wrong");
  a_irq_holds:
    assert property (intrq_out && !stat_rd && !$past(stat_rd) |=> intrq_out) else $error("interrupt lost");
  a_reset_state:
    assert property (!$past(rst_n_in) |-> !intrq_out && por_restore_out && ecc_bytes_out == 8'h04
      && current_limit_out == 8'hFF) else $error("reset state wrong");
endmodule : arsf_checker
bind arsf_top arsf_checker u_chk (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
  .s_axi_awvalid_in(s_axi_awvalid_in), .s_axi_awready_out(s_axi_awready_out), .s_axi_wvalid_in(s_axi_wvalid_in),
  .s_axi_wready_out(s_axi_wready_out), .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_araddr_in(s_axi_araddr_in),
  .s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out), .s_axi_rdata_out(s_axi_rdata_out),
  .s_axi_rresp_out(s_axi_rresp_out), .s_axi_rvalid_out(s_axi_rvalid_out), .media_req_out(media_req_out),
  .media_lba_out(media_lba_out), .flush_req_out(flush_req_out), .intrq_out(intrq_out),
  .por_restore_out(por_restore_out), .ecc_bytes_out(ecc_bytes_out), .current_limit_out(current_limit_out));
`default_nettype wire

/* File: tb/arsf_media_model.sv */
`timescale 1ns/10ps
`default_nettype none
module arsf_media_model
  import arsf_pkg::*;
(
  input wire logic clk_in, // Clock
  input wire logic req_in, // Fetch pulse
  input wire logic [27:0] lba_in, // Sector to fetch
  input wire logic [27:0] err_lba_in, // Sector that fails
  input wire logic err_en_in, // Error injection on
  input wire logic [7:0] delay_in, // Access latency
  output logic wvalid_out, // Word valid
  output logic [31:0] wdata_out, // Word
  output logic done_out, // Fetch done
  output logic err_out, // Fetch failed
  input wire logic flush_req_in, // Flush pulse
  output logic flush_done_out // Flush done
);
  logic [27:0] l;
  // ==========================================
  // Sector fetch, words tagged by address
  initial begin
    wvalid_out = 1'b0;
    wdata_out = 32'h0;
    done_out = 1'b0;
    err_out = 1'b0;
    forever begin
      @(posedge clk_in);
      if (req_in === 1'b1) begin
        l = lba_in;
        repeat (delay_in) @(posedge clk_in);
        for (int i = 0; i < SECTOR_WORDS; i++) begin
          wvalid_out <= 1'b1;
          wdata_out <= {l[23:0], 8'(i)};
          @(posedge clk_in);
        end
        wvalid_out <= 1'b0;
        wdata_out <= ~wdata_out;
        done_out <= 1'b1;
        err_out <= err_en_in && (l == err_lba_in);
        @(posedge clk_in);
        done_out <= 1'b0;
        err_out <= 1'b0;
        wdata_out <= ~wdata_out;
      end
    end
  end
  // ==========================================
  // Cache flush
  initial begin
    flush_done_out = 1'b0;
    forever begin
      @(posedge clk_in);
      if (flush_req_in === 1'b1) begin
        repeat (delay_in) @(posedge clk_in);
        flush_done_out <= 1'b1;
        @(posedge clk_in);
        flush_done_out <= 1'b0;
      end
    end
  end
endmodule : arsf_media_model
`default_nettype wire

/* File: tb/arsf_top_bench.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin mismatches++; \
  $display("mismatch at %0t: got %0h expected %0h", $time, got, exp); end end
module arsf_top_bench;
  import arsf_pkg::*;
  logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [5:0] awaddr, araddr;
  logic [31:0] wdata, rdata, mwd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic mreq, mwv, mdone, merr, freq, fdone, intrq, eight, wc, apm, pl1, ext, la, por, err_en;
  logic [27:0] mlba, err_lba;
  logic [7:0] xmode, apml, ecc, cur, dly;
  int mismatches, compares, cycles;
  localparam logic [31:0] FT_TAB [27] = '{32'h0100_4904, 32'h8100_0904, 32'h0200_2904, 32'h8200_0904,
    32'h0580_1904, 32'h05FF_9904, 32'h8500_0904, 32'h8A00_0104, 32'h0A00_0904, 32'h0900_0D04, 32'h8900_0904,
    32'hAA00_0B04, 32'h5500_0904, 32'h6600_0804, 32'hCC00_0904, 32'h4400_0908, 32'hBB00_0904, 32'h6900_0904,
    32'h9600_0904, 32'h9700_0904, 32'h9A06_0904, 32'h0308_0904, 32'h0342_0904, 32'h0302_8904,
    32'h0322_0904, 32'h0310_8904, 32'h0000_8904};
  arsf_top #(.ECC_VENDOR_BYTES(8'h08)) DUT (
    .sys_clk_in(clk), .rst_n_in(rst_n), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .media_req_out(mreq),
    .media_lba_out(mlba), .media_wvalid_in(mwv), .media_wdata_in(mwd), .media_done_in(mdone),
    .media_err_in(merr), .flush_req_out(freq), .flush_done_in(fdone), .intrq_out(intrq),
    .eight_bit_out(eight), .wcache_out(wc), .xfer_mode_out(xmode), .apm_on_out(apm), .apm_level_out(apml),
    .pl1_on_out(pl1), .ext_pwr_out(ext), .lookahead_out(la), .por_restore_out(por), .ecc_bytes_out(ecc),
    .current_limit_out(cur));
  arsf_media_model u_media (.clk_in(clk), .req_in(mreq), .lba_in(mlba), .err_lba_in(err_lba), .err_en_in(err_en),
    .delay_in(dly), .wvalid_out(mwv), .wdata_out(mwd), .done_out(mdone), .err_out(merr), .flush_req_in(freq),
    .flush_done_out(fdone));
  always #5 clk = ~clk;
  // ==========================================
  // Bus tasks
  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    logic aw_p;
    logic w_p;
    aw_p = 1'b1;
    w_p = 1'b1;
    @(posedge clk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (aw_p && awready) begin
        aw_p = 1'b0;
        awvalid <= 1'b0;
      end
      if (w_p && wready) begin
        w_p = 1'b0;
        wvalid <= 1'b0;
      end
    end while (!(bvalid === 1'b1 && !aw_p && !w_p));
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] idx, output logic [31:0] d);
    @(posedge clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    rready <= 1'b0;
  endtask : rd
  task automatic irq_st(output logic [31:0] st);
    int n;
    n = 0;
    while (intrq !== 1'b1 && n < 40000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 40000) `CHK(1'b0, 1'b1)
    rd(IDX_COMMAND, st);
  endtask : irq_st
  task automatic set_addr(input logic [27:0] a, input logic [7:0] cnt);
    wr(IDX_ADDR_LOW, a[7:0]);
    wr(IDX_ADDR_MID, a[15:8]);
    wr(IDX_ADDR_HIGH, a[23:16]);
    wr(IDX_DRIVE, {4'hE, a[27:24]});
    wr(IDX_COUNT, cnt);
  endtask : set_addr
  task automatic rd_sector(input logic [23:0] l);
    logic [31:0] d;
    irq_st(d);
    `CHK(d[7:0] & 8'hC9, 8'h48)
    for (int i = 0; i < SECTOR_WORDS; i++) begin
      rd(IDX_DATA, d);
      `CHK(d, {l, 8'(i)})
    end
  endtask : rd_sector
  // ==========================================
  // Scenarios
  task automatic t_reset;
    logic [31:0] d;
    rd(IDX_COUNT, d);
    `CHK(d[7:0], 8'h01)
    wr(IDX_DRIVE, 8'h00);
    `CHK(bresp, RESP_OKAY)
    rd(IDX_DRIVE, d);
    `CHK(d[7:0], 8'hA0)
    rd(4'h8, d);
    `CHK(rresp, RESP_DECERR)
    wr(4'h8, 8'h00);
    `CHK(bresp, RESP_DECERR)
  endtask : t_reset
  task automatic t_read;
    logic [31:0] d;
    set_addr(28'h00000FF, 8'h02);
    wr(IDX_COMMAND, OP_READ0);
    rd_sector(24'h0000FF);
    rd_sector(24'h000100);
    repeat (5) @(posedge clk);
    `CHK(intrq, 1'b0)
    rd(IDX_COMMAND, d);
    `CHK(d[7:0] & 8'hC9, 8'h40)
    rd(IDX_ADDR_MID, d);
    `CHK(d[7:0], 8'h01)
    err_lba = 28'h0000300;
    err_en = 1'b1;
    set_addr(28'h00002FF, 8'h03);
    wr(IDX_COMMAND, OP_READ1);
    rd_sector(24'h0002FF);
    irq_st(d);
    `CHK(d[7:0] & 8'hC9, 8'h41)
    rd(IDX_FEATURE, d);
    `CHK(d[6], 1'b1)
    rd(IDX_ADDR_LOW, d);
    `CHK(d[7:0], 8'h00)
  endtask : t_read
  task automatic t_verify;
    logic [31:0] d;
    err_lba = 28'h0000012;
    dly = 8'h00;
    set_addr(28'h0000010, 8'h05);
    wr(IDX_COMMAND, OP_VERIFY0);
    irq_st(d);
    `CHK(d[7:0] & 8'hC9, 8'h41)
    rd(IDX_COUNT, d);
    `CHK(d[7:0], 8'h03)
    rd(IDX_ADDR_LOW, d);
    `CHK(d[7:0], 8'h12)
    err_en = 1'b0;
    set_addr(28'h0000200, 8'h00);
    wr(IDX_COMMAND, OP_VERIFY1);
    rd(IDX_COMMAND, d);
    `CHK(d[7], 1'b1)
    irq_st(d);
    `CHK(d[7:0] & 8'hC9, 8'h40)
    rd(IDX_ADDR_LOW, d);
    `CHK(d[7:0], 8'hFF)
    rd(IDX_ADDR_MID, d);
    `CHK(d[7:0], 8'h02)
  endtask : t_verify
  task automatic t_nops;
    logic [31:0] d;
    wr(IDX_COMMAND, 8'h1A);
    irq_st(d);
    `CHK(d[7:0] & 8'hC9, 8'h40)
    set_addr(28'h0100000, 8'h01);
    wr(IDX_COMMAND, 8'h75);
    irq_st(d);
    `CHK(d[7:0] & 8'hC9, 8'h41)
    rd(IDX_FEATURE, d);
    `CHK(d[4], 1'b1)
    set_addr(28'h00FFFFF, 8'h01);
    wr(IDX_COMMAND, 8'h70);
    irq_st(d);
    `CHK(d[7:0] & 8'hC9, 8'h40)
  endtask : t_nops
  task automatic t_features;
    logic [31:0] d;
    logic [31:0] e;
    dly = 8'h0C;
    for (int i = 0; i < 27; i++) begin
      e = FT_TAB[i];
      wr(IDX_COUNT, e[23:16]);
      wr(IDX_FEATURE, e[31:24]);
      wr(IDX_COMMAND, OP_SET_FEATURES);
      irq_st(d);
      `CHK(d[0], e[15])
      `CHK({eight, wc, apm, pl1, ext, la, por}, e[14:8])
      `CHK(ecc, e[7:0])
    end
    `CHK(xmode, 8'h22)
    `CHK(apml, 8'h80)
    `CHK(cur, 8'h06)
    rd(IDX_ADDR_MID, d);
    `CHK(d[7:0], 8'h01)
    rd(IDX_ADDR_HIGH, d);
    `CHK(d[7:0], 8'h64)
  endtask : t_features
  // ==========================================
  // Run control
  task automatic end_of_test;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test
  always @(posedge clk) begin
    cycles++;
    if (cycles == 80000) begin
      mismatches++;
      end_of_test();
    end
  end
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, err_en} = '0;
    {awaddr, araddr, wdata, err_lba} = '0;
    wstrb = 4'h1;
    dly = 8'h03;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_read();
    t_verify();
    t_nops();
    t_features();
    end_of_test();
  end
endmodule : arsf_top_bench
`default_nettype wire
